// ### common/pclr_consts.vh
// Constants for the cache line / latency register block
`ifndef PCLR_CONSTS_VH
`define PCLR_CONSTS_VH
`define PCLR_ADDR_W 4
`define PCLR_OFS_MAIN 4'h0
`define PCLR_OFS_CTRL 4'h1
`define PCLR_OFS_STAT 4'h2
`define PCLR_SELFTEST_VAL 8'h00
`define PCLR_HDR_DEFAULT 8'h00
`define PCLR_LAT_RESET 8'h00
`define PCLR_CLS_RESET 8'h00
`define PCLR_PREFETCH_MIN 8'h01
`define PCLR_CLS_OFF 8'h00
`define PCLR_CLS_16 8'h04
`define PCLR_CLS_32 8'h08
`define PCLR_CLS_64 8'h10
`define PCLR_CLS_128 8'h20
`define PCLR_CMD_MEMRD 4'h6
`define PCLR_CMD_MEMWR 4'h7
`define PCLR_CMD_MEMRDMULT 4'hC
`define PCLR_CMD_MEMRDLINE 4'hE
`define PCLR_CMD_MEMWRINV 4'hF
`define PCLR_BYTE0 7:0
`define PCLR_BYTE1 15:8
`define PCLR_BYTE2 23:16
`define PCLR_BYTE3 31:24
`define PCLR_CTRL_MWI 0
`define PCLR_CTRL_MULTI 1
`endif

// ### rtl/pclr_hold_timer.v
// Bus hold limit counter for master bursts
`timescale 1ns/10ps
`default_nettype none
`include "pclr_consts.vh"
module pclr_hold_timer (
  input wire core_clk,
  input wire nrst,
  input wire frameStart,
  input wire burstActive,
  input wire grantSync,
  input wire [7:0] holdLimit,
  output reg expired_q
);
  reg [7:0] count_q;
  reg [7:0] count_d;
  always @* begin
    count_d = count_q;
    if (frameStart) begin
      count_d = holdLimit;
    end else if (burstActive && count_q != 8'h00) begin
      count_d = count_q - 8'h01;
    end
  end
  always @(posedge core_clk) begin
    if (!nrst) begin
      count_q <= 8'h00;
      expired_q <= 1'b0;
    end else begin
      count_q <= count_d;
      // Grant held means the limit never applies
      expired_q <= burstActive && !frameStart && count_d == 8'h00 &&
        !grantSync;
    end
  end
endmodule // pclr_hold_timer
`default_nettype wire

// ### rtl/pclr_line_decode.v
// Cache line size legality and prefetch size decode
`timescale 1ns/10ps
`default_nettype none
`include "pclr_consts.vh"
module pclr_line_decode (
  input wire [7:0] lineIn,
  output reg [7:0] lineLegal,
  output reg [7:0] prefetchWords
);
  always @* begin
    case (lineIn)
      `PCLR_CLS_OFF, `PCLR_CLS_16, `PCLR_CLS_32,
      `PCLR_CLS_64, `PCLR_CLS_128: lineLegal = lineIn;
      default: lineLegal = `PCLR_CLS_OFF;
    endcase
    // Disabled line size still prefetches one word
    if (lineLegal == `PCLR_CLS_OFF) begin
      prefetchWords = `PCLR_PREFETCH_MIN;
    end else begin
      prefetchWords = lineLegal;
    end
  end
endmodule // pclr_line_decode
`default_nettype wire

// ### rtl/pclr_register.v
// Self-test, header, bus hold limit and line length register
//
// Contract
// - Self-test byte reads zero, writes ignored
// - Header byte reports layout and function count
// - Host loads hold limit in bus cycles
// - Grant kept whole transaction: no limit applied
// - Hold limit zero on hardware reset
// - Software reset keeps hold limit
// - Host loads line length in words
// - Line length picks master memory command
// - Line length sets slave prefetch size
// - Unsupported line length stores zero
// - Legal: 0h, 4h, 8h
// - Legal: 10h, 20h too
`timescale 1ns/10ps
`default_nettype none
`include "pclr_consts.vh"
module pclr_register (
  input wire core_clk,
  input wire nrst,
  input wire swResetN,
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata_q,
  input wire busGrantPinN,
  input wire framePinN,
  input wire masterReq,
  input wire masterIsWrite,
  input wire [7:0] masterWords,
  output reg [3:0] memCommand_q,
  output reg burstStop_q,
  output reg [7:0] prefetchWords_q,
  output reg [7:0] holdLimit_q,
  output reg [7:0] lineLength_q
);
  reg grantMeta_q;
  reg grantSync_q;
  reg frameMeta_q;
  reg frameSync_q;
  reg frameLast_q;
  reg burst_q;
  reg [1:0] ctrl_q;
  wire [7:0] headerByte;
  reg [31:0] rdata_d;
  reg [3:0] cmd_d;
  reg swHold_q;
  wire [7:0] lineLegal;
  wire [7:0] prefetchWords;
  wire expired;
  wire frameStart;
  wire frameEnd;
  wire mainWrite;
  wire lineMultiple;

  assign mainWrite = regWrite && regAddr == `PCLR_OFS_MAIN;
  // Pins are active low, two stages before use
  assign frameStart = !frameSync_q && frameLast_q;
  assign frameEnd = frameSync_q && !frameLast_q;
  assign lineMultiple = masterWords > lineLength_q;
  // Straight from control, so a read right after a write sees it
  assign headerByte = `PCLR_HDR_DEFAULT |
    {ctrl_q[`PCLR_CTRL_MULTI], 7'h00};

  pclr_line_decode uDecode (
    .lineIn(regWdata[`PCLR_BYTE0]),
    .lineLegal(lineLegal),
    .prefetchWords()
  );

  pclr_line_decode uPrefetch (
    .lineIn(lineLength_q),
    .lineLegal(),
    .prefetchWords(prefetchWords)
  );

  pclr_hold_timer uTimer (
    .core_clk(core_clk),
    .nrst(nrst),
    .frameStart(frameStart),
    .burstActive(burst_q),
    .grantSync(!grantSync_q),
    .holdLimit(holdLimit_q),
    .expired_q(expired)
  );

  always @(posedge core_clk) begin
    if (!nrst) begin
      grantMeta_q <= 1'b1;
      grantSync_q <= 1'b1;
      frameMeta_q <= 1'b1;
      frameSync_q <= 1'b1;
      frameLast_q <= 1'b1;
    end else begin
      grantMeta_q <= busGrantPinN;
      grantSync_q <= grantMeta_q;
      frameMeta_q <= framePinN;
      frameSync_q <= frameMeta_q;
      frameLast_q <= frameSync_q;
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      holdLimit_q <= `PCLR_LAT_RESET;
      lineLength_q <= `PCLR_CLS_RESET;
      ctrl_q <= 2'b00;
      swHold_q <= 1'b0;
    end else begin
      swHold_q <= !swResetN;
      if (!swResetN) begin
        // Soft reset clears line length and control only
        lineLength_q <= `PCLR_CLS_RESET;
        ctrl_q <= 2'b00;
      end else if (mainWrite) begin
        holdLimit_q <= regWdata[`PCLR_BYTE1];
        lineLength_q <= lineLegal;
      end else if (regWrite && regAddr == `PCLR_OFS_CTRL) begin
        ctrl_q <= regWdata[1:0];
      end
    end
  end

  always @* begin
    case (regAddr)
      `PCLR_OFS_MAIN: rdata_d = {`PCLR_SELFTEST_VAL, headerByte,
        holdLimit_q, lineLength_q};
      `PCLR_OFS_CTRL: rdata_d = {30'h00000000, ctrl_q};
      `PCLR_OFS_STAT: rdata_d = {21'h000000, swHold_q, burst_q,
        expired, prefetchWords};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @* begin
    if (masterIsWrite) begin
      // MWI only on whole lines, when enabled
      if (ctrl_q[`PCLR_CTRL_MWI] && lineLength_q != `PCLR_CLS_OFF &&
          masterWords >= lineLength_q) begin
        cmd_d = `PCLR_CMD_MEMWRINV;
      end else begin
        cmd_d = `PCLR_CMD_MEMWR;
      end
    end else if (lineLength_q == `PCLR_CLS_OFF) begin
      cmd_d = `PCLR_CMD_MEMRD;
    end else if (lineMultiple) begin
      cmd_d = `PCLR_CMD_MEMRDMULT;
    end else if (masterWords > 8'h01) begin
      cmd_d = `PCLR_CMD_MEMRDLINE;
    end else begin
      cmd_d = `PCLR_CMD_MEMRD;
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      regRdata_q <= 32'h00000000;
      memCommand_q <= `PCLR_CMD_MEMRD;
      burstStop_q <= 1'b0;
      prefetchWords_q <= `PCLR_PREFETCH_MIN;
      burst_q <= 1'b0;
    end else begin
      regRdata_q <= regRead ? rdata_d : 32'h00000000;
      if (masterReq) begin
        memCommand_q <= cmd_d;
      end
      prefetchWords_q <= prefetchWords;
      if (frameStart) begin
        burst_q <= 1'b1;
      end else if (frameEnd) begin
        burst_q <= 1'b0;
      end
      // Expiry can latch as the frame closes; only stop inside a burst
      burstStop_q <= expired && burst_q && !frameEnd;
    end
  end
endmodule // pclr_register
`default_nettype wire

// ### tb/pclr_bus_model.sv
// Bus partner: frame and grant pins of one burst
`timescale 1ns/10ps
`default_nettype none
module pclr_bus_model (
  input wire logic core_clk,
  input wire logic start,
  input wire logic keepGrant,
  output logic busGrantPinN,
  output logic framePinN
);
  logic [3:0] cnt_q = 4'h0;
  always @(posedge core_clk) begin
    if (start) begin
      cnt_q <= 4'hC;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign framePinN = cnt_q == 4'h0;
  // Pulled up outside frames; grant taken back mid-burst unless keepGrant is set
  assign busGrantPinN = framePinN || (cnt_q < 4'h9 && !keepGrant);
endmodule // pclr_bus_model
`default_nettype wire

// ### tb/pclr_checker.sv
// Assertions on the register block ports
`timescale 1ns/10ps
`default_nettype none
module pclr_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic swResetN,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata_q,
  input wire logic busGrantPinN,
  input wire logic masterReq,
  input wire logic masterIsWrite,
  input wire logic [3:0] memCommand_q,
  input wire logic burstStop_q,
  input wire logic [7:0] prefetchWords_q,
  input wire logic [7:0] holdLimit_q,
  input wire logic [7:0] lineLength_q
);
  wire logic legal = regWdata[7:0] inside {8'h00,8'h04,8'h08,8'h10,8'h20};
  wire logic wrMain = regWrite && swResetN && regAddr == 4'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_SELF_TEST_BYTE: assert property (regRead |=> regRdata_q[31:24] == 8'h00)
    else $error("self test byte");
  AST_HOLDW: assert property (wrMain |=> holdLimit_q == $past(regWdata[15:8]))
    else $error("hold limit write");
  AST_RST: assert property ($rose(nrst) |-> holdLimit_q == 8'h00)
    else $error("hold limit reset");
  AST_SWKEEP: assert property (!swResetN && !regWrite |=> $stable(holdLimit_q))
    else $error("hold limit soft reset");
  AST_LOAD: assert property (wrMain |=>
    lineLength_q == ($past(legal) ? $past(regWdata[7:0]) : 8'h00))
    else $error("line length store");
  AST_PREF: assert property ((lineLength_q == 8'h10) [*3] |->
    prefetchWords_q == 8'h10) else $error("prefetch size");
  AST_CMD: assert property (masterReq && masterIsWrite && lineLength_q == 8'h00
    |=> memCommand_q == 4'h7) else $error("command choice");
  AST_STOP: assert property ((!busGrantPinN) [*5] |-> !$rose(burstStop_q))
    else $error("stop with grant");
endmodule // pclr_checker
bind pclr_register pclr_checker uChk (.core_clk(core_clk), .nrst(nrst),
  .swResetN(swResetN), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata_q(regRdata_q),
  .busGrantPinN(busGrantPinN), .masterReq(masterReq),
  .masterIsWrite(masterIsWrite), .memCommand_q(memCommand_q),
  .burstStop_q(burstStop_q), .prefetchWords_q(prefetchWords_q),
  .holdLimit_q(holdLimit_q), .lineLength_q(lineLength_q));
`default_nettype wire

// ### tb/test_pci_cacheline_latency_register.sv
// Testbench for the cache line and bus hold register
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin samplesChecked++; if ((a)!==(b)) begin failCount++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module test_pci_cacheline_latency_register;
  logic core_clk = 0, nrst = 0, swResetN = 1, regWrite = 0, regRead = 0;
  logic masterReq = 0, masterIsWrite = 0, start = 0, keepGrant = 0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [7:0] masterWords = 8'h01, v;
  logic [7:0] lv [10] = '{8'h04, 8'h01, 8'h08, 8'h05, 8'h10, 8'h11,
    8'h20, 8'h21, 8'h0F, 8'hFF};
  wire logic [31:0] regRdata_q;
  wire logic [3:0] memCommand_q;
  wire logic burstStop_q, busGrantPinN, framePinN;
  wire logic [7:0] prefetchWords_q, holdLimit_q, lineLength_q;
  int failCount = 0, samplesChecked = 0, cyc = 0, n;
  always #5 core_clk = ~core_clk;
  pclr_register DUT (.core_clk(core_clk), .nrst(nrst), .swResetN(swResetN),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata_q(regRdata_q), .busGrantPinN(busGrantPinN),
    .framePinN(framePinN), .masterReq(masterReq),
    .masterIsWrite(masterIsWrite), .masterWords(masterWords),
    .memCommand_q(memCommand_q), .burstStop_q(burstStop_q),
    .prefetchWords_q(prefetchWords_q), .holdLimit_q(holdLimit_q),
    .lineLength_q(lineLength_q));
  pclr_bus_model BUS (.core_clk(core_clk), .start(start),
    .keepGrant(keepGrant), .busGrantPinN(busGrantPinN), .framePinN(framePinN));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    `CHK(regRdata_q, e)
  endtask
  task automatic burst(input logic k);
    keepGrant <= k;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
  endtask
  task automatic mc(input logic w, input logic [7:0] m, input logic [3:0] e);
    masterIsWrite <= w;
    masterWords <= m;
    masterReq <= 1'b1;
    @(posedge core_clk);
    masterReq <= 1'b0;
    #1;
    `CHK(memCommand_q, e)
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bound well past the hundred or so cycles the tests take
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failCount++;
      giveVerdict;
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    rd(4'h0, 32'h0);
    wr(4'h0, 32'hFFFF_0304);
    rd(4'h0, 32'h0000_0304);
    foreach (lv[i]) begin
      wr(4'h0, {16'h0, 8'h09, lv[i]});
      v = (lv[i] inside {8'h04, 8'h08, 8'h10, 8'h20}) ? lv[i] : 8'h00;
      rd(4'h0, {16'h0, 8'h09, v});
      `CHK(lineLength_q, v)
      `CHK(prefetchWords_q, (v == 8'h00) ? 8'h01 : v)
    end
    wr(4'h1, 32'h2);
    rd(4'h0, 32'h0080_0900);
    rd(4'hF, 32'h0);
    $display("register tests done");
    swResetN <= 1'b0;
    @(posedge core_clk);
    swResetN <= 1'b1;
    #1;
    rd(4'h0, 32'h0000_0900);
    `CHK(holdLimit_q, 8'h09)
    $display("soft reset test done");
    mc(1'b1, 8'h01, 4'h7);
    wr(4'h0, 32'h0000_0210);
    wr(4'h1, 32'h1);
    mc(1'b1, 8'h10, 4'hF);
    mc(1'b1, 8'h08, 4'h7);
    mc(1'b0, 8'h20, 4'hC);
    mc(1'b0, 8'h08, 4'hE);
    mc(1'b0, 8'h01, 4'h6);
    $display("command tests done");
    burst(1'b0);
    for (n = 0; n < 30 && burstStop_q !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(burstStop_q, 1'b1)
    repeat (20) @(posedge core_clk);
    #1;
    `CHK(burstStop_q, 1'b0)
    burst(1'b1);
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      #1;
      `CHK(burstStop_q, 1'b0)
    end
    $display("burst tests done");
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    rd(4'h0, 32'h0);
    `CHK(prefetchWords_q, 8'h01)
    `CHK(memCommand_q, 4'h6)
    $display("hardware reset test done");
    giveVerdict;
  end
endmodule // test_pci_cacheline_latency_register
`default_nettype wire
